// *** src/pbao_top.sv ***
`timescale 1ns/100ps
module pbao_top
   import pbao_pkg::*;
(
   // Clock and reset.
   input  wire logic                i_sys_clk,
   input  wire logic                i_rst,
   // Port registers and pin levels.
   input  wire logic [PORT_W-1:0]   i_port_out,
   input  wire logic [PORT_W-1:0]   i_dir,
   input  wire logic [PORT_W-1:0]   i_pin_in,
   input  wire logic                i_sleep,
   // Serial shift unit.
   input  wire logic                i_ssu_two_wire,
   input  wire logic                i_ssu_three_wire,
   input  wire logic                i_shift_out,
   input  wire logic                i_ssu_start_irq_en,
   // Timers and programming.
   input  wire logic                i_prog_mode,
   input  wire logic                i_cmp_a_inv_en,
   input  wire logic                i_cmp_a_inv_wave,
   input  wire logic                i_timer0_external_clock_sel,
   // Interrupt enables.
   input  wire logic                i_global_irq_en,
   input  wire logic                i_pin_change_group0_en,
   input  wire logic                i_pin_change_group1_en,
   input  wire logic                i_external_irq0_bit,
   // Fuse decodes.
   input  wire logic                i_reset_pin_select,
   input  wire logic                i_xtal_in_pin_as_io,
   input  wire logic                i_xtal_out_pin_as_io,
   input  wire logic                i_external_clock_sel,
   // Pad controls.
   output logic      [PORT_W-1:0]   o_pin_out,
   output logic      [PORT_W-1:0]   o_pin_oe,
   output logic      [PORT_W-1:0]   o_pullup_en,
   output logic      [PORT_W-1:0]   o_input_en,
   // Peripheral side.
   output logic                     o_shift_data_in,
   output logic                     o_external_irq0_en,
   output logic                     o_pin0_change_en,
   output logic      [GRP1_W-1:0]   o_grp1_change_en
);

   logic              pc0_on;
   logic              pc1_on;
   logic              external_irq0_on;
   logic              cmp_a_on;
   logic              sda_drive;
   logic [PORT_W-1:0] pullup_override_en;
   logic [PORT_W-1:0] pullup_override_val;
   logic [PORT_W-1:0] direction_override_en;
   logic [PORT_W-1:0] direction_override_val;
   logic [PORT_W-1:0] port_value_override_en;
   logic [PORT_W-1:0] port_value_override_val;
   logic [PORT_W-1:0] input_enable_override_en;
   logic [PORT_W-1:0] input_enable_override_val;
   logic [PORT_W-1:0] res_pull;
   logic [PORT_W-1:0] res_dir;
   logic [PORT_W-1:0] res_val;
   logic [PORT_W-1:0] res_inen;
   logic [GRP1_W-1:0] next_grp1;
   logic              next_pc0;
   logic [OUT_W-1:0]  next_out;
   logic [OUT_W-1:0]  out_q;

   // Qualified enables for the pin logic below; only pc1_on is shared by several pins.
   always_comb
   begin
      pc0_on    = i_global_irq_en & i_pin_change_group0_en;
      pc1_on    = i_global_irq_en & i_pin_change_group1_en;
      external_irq0_on   = i_global_irq_en & i_external_irq0_bit;
      // The compare waveform yields to programming and to either shifter mode.
      cmp_a_on  = i_cmp_a_inv_en & ~i_prog_mode
                  & ~i_ssu_two_wire & ~i_ssu_three_wire;
      // Open-collector data: pull low on a zero from either source.
      sda_drive = (~i_shift_out | ~i_port_out[PIN_SDA]) & i_dir[PIN_SDA];
   end

   // Pin 0 overrides. Three-wire mode only masks other overrides here and forces none, so
   // software must keep the pin an input for the shifter to see the line.
   always_comb
   begin
      pullup_override_en  = '0;
      pullup_override_val  = '0;
      direction_override_en  = '0;
      direction_override_val  = '0;
      port_value_override_en  = '0;
      port_value_override_val  = '0;
      input_enable_override_en = '0;
      input_enable_override_val = '0;
      pullup_override_en[PIN_SDA]  = i_ssu_two_wire;
      pullup_override_val[PIN_SDA]  = OVR_OFF;
      direction_override_en[PIN_SDA]  = i_ssu_two_wire;
      direction_override_val[PIN_SDA]  = sda_drive;
      port_value_override_en[PIN_SDA]  = (i_ssu_two_wire & i_dir[PIN_SDA]) | cmp_a_on;
      port_value_override_val[PIN_SDA]  = cmp_a_on & ~(i_ssu_two_wire & i_dir[PIN_SDA])
                       & i_cmp_a_inv_wave;
      input_enable_override_en[PIN_SDA] = (~(i_ssu_two_wire | i_ssu_three_wire | cmp_a_on) & pc0_on)
                       | i_ssu_start_irq_en;
      input_enable_override_val[PIN_SDA] = INPUT_ON_VAL;

      // Pin 7: reset pin selection.
      pullup_override_en[PIN_RST]  = i_reset_pin_select;
      pullup_override_val[PIN_RST]  = RST_PULL_VAL;
      direction_override_en[PIN_RST]  = i_reset_pin_select;
      direction_override_val[PIN_RST]  = RST_DIR_VAL;
      input_enable_override_en[PIN_RST] = pc1_on | i_reset_pin_select;
      input_enable_override_val[PIN_RST] = pc1_on & ~i_reset_pin_select;

      // Pin 6: external interrupt and timer clock input.
      input_enable_override_en[PIN_EXTERNAL_IRQ0] = (pc1_on & ~i_timer0_external_clock_sel) | external_irq0_on;
      input_enable_override_val[PIN_EXTERNAL_IRQ0] = INPUT_ON_VAL;

      // Pin 5: crystal output.
      pullup_override_en[PIN_XOUT]  = ~i_xtal_out_pin_as_io;
      pullup_override_val[PIN_XOUT]  = XTAL_PULL_VAL;
      direction_override_en[PIN_XOUT]  = ~i_xtal_out_pin_as_io;
      direction_override_val[PIN_XOUT]  = XTAL_DIR_VAL;
      input_enable_override_en[PIN_XOUT] = pc1_on | ~i_xtal_out_pin_as_io;
      input_enable_override_val[PIN_XOUT] = pc1_on & i_xtal_out_pin_as_io;

      // Pin 4: crystal input, which also carries an external clock.
      pullup_override_en[PIN_XIN]  = ~i_xtal_in_pin_as_io;
      pullup_override_val[PIN_XIN]  = XTAL_PULL_VAL;
      direction_override_en[PIN_XIN]  = ~i_xtal_in_pin_as_io;
      direction_override_val[PIN_XIN]  = XTAL_DIR_VAL;
      input_enable_override_en[PIN_XIN] = pc1_on | ~i_xtal_in_pin_as_io
                       | i_external_clock_sel;
      input_enable_override_val[PIN_XIN] = (pc1_on & i_xtal_in_pin_as_io)
                       | i_external_clock_sel;

      // Pins 7 to 4 keep the port output value untouched.
      port_value_override_en[PIN_RST:PIN_XIN] = {GRP1_W{OVR_OFF}};
      port_value_override_val[PIN_RST:PIN_XIN] = {GRP1_W{OVR_OFF}};
   end

   // Change interrupt gating per pin, masked by the owning alternate function.
   always_comb
   begin
      next_pc0 = pc0_on & ~cmp_a_on
                 & ~i_ssu_two_wire & ~i_ssu_three_wire;
      next_grp1[PIN_XIN-PIN_XIN]  = pc1_on & i_xtal_in_pin_as_io
                                    & ~i_external_clock_sel;
      next_grp1[PIN_XOUT-PIN_XIN] = pc1_on & i_xtal_out_pin_as_io;
      next_grp1[PIN_EXTERNAL_IRQ0-PIN_XIN] = pc1_on & ~external_irq0_on
                                    & ~i_timer0_external_clock_sel;
      next_grp1[PIN_RST-PIN_XIN]  = pc1_on & ~i_reset_pin_select;
   end

   // Final attribute selection for all eight pins.
   pbao_ovr_mux #(
      .W (PORT_W)
   ) u_mux (
      .i_port_out (i_port_out),
      .i_dir      (i_dir),
      .i_sleep    (i_sleep),
      .i_pullup_override_en     (pullup_override_en),
      .i_pullup_override_val     (pullup_override_val),
      .i_direction_override_en     (direction_override_en),
      .i_direction_override_val     (direction_override_val),
      .i_port_value_override_en     (port_value_override_en),
      .i_port_value_override_val     (port_value_override_val),
      .i_input_enable_override_en    (input_enable_override_en),
      .i_input_enable_override_val    (input_enable_override_val),
      .o_pull     (res_pull),
      .o_dir      (res_dir),
      .o_val      (res_val),
      .o_inen     (res_inen)
   );

   // Gather everything that leaves the block into one registered word.
   always_comb
   begin
      next_out                          = OUT_RESET;
      next_out[OFS_VAL +: PORT_W]       = res_val;
      next_out[OFS_OE +: PORT_W]        = res_dir;
      next_out[OFS_PULL +: PORT_W]      = res_pull;
      next_out[OFS_INEN +: PORT_W]      = res_inen;
      next_out[OFS_SHIN]                = i_pin_in[PIN_SDA];
      next_out[OFS_EXTERNAL_IRQ0]                = external_irq0_on;
      next_out[OFS_PC0]                 = next_pc0;
      next_out[OFS_GRP1 +: GRP1_W]      = next_grp1;
   end

   pbao_out_reg #(
      .W   (OUT_W),
      .RST (OUT_RESET)
   ) u_out (
      .i_sys_clk (i_sys_clk),
      .i_rst     (i_rst),
      .i_d       (next_out),
      .o_q       (out_q)
   );

   // Output slices; each is a flop of the output bank.
   assign o_pin_out          = out_q[OFS_VAL +: PORT_W];
   assign o_pin_oe           = out_q[OFS_OE +: PORT_W];
   assign o_pullup_en        = out_q[OFS_PULL +: PORT_W];
   assign o_input_en         = out_q[OFS_INEN +: PORT_W];
   assign o_shift_data_in    = out_q[OFS_SHIN];
   assign o_external_irq0_en = out_q[OFS_EXTERNAL_IRQ0];
   assign o_pin0_change_en   = out_q[OFS_PC0];
   assign o_grp1_change_en   = out_q[OFS_GRP1 +: GRP1_W];

   // Checks: every output follows its cause by exactly one clock.
   // Attempts that start on an edge sampling reset are skipped, since that edge loads zeros.
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (i_rst);

   a_three_wire_in: assert property (
      i_ssu_three_wire && !i_ssu_two_wire && !i_cmp_a_inv_en
      |=> o_shift_data_in == $past(i_pin_in[PIN_SDA])
          && o_pin_oe[PIN_SDA] == $past(i_dir[PIN_SDA]))
      else $error("three-wire mode disturbed pin 0");

   a_sda_drive_low: assert property (
      i_ssu_two_wire && i_dir[PIN_SDA] && !(i_port_out[PIN_SDA] && i_shift_out)
      |=> o_pin_oe[PIN_SDA] && !o_pin_out[PIN_SDA])
      else $error("data line not pulled low");

   a_sda_release: assert property (
      i_ssu_two_wire && !(i_dir[PIN_SDA] && !(i_port_out[PIN_SDA] && i_shift_out))
      |=> !o_pin_oe[PIN_SDA])
      else $error("data line driven while it should float");

   a_sda_pull_off: assert property (
      i_ssu_two_wire |=> !o_pullup_en[PIN_SDA])
      else $error("pull-up on in two-wire mode");

   a_pwm_route: assert property (
      !i_prog_mode && !i_ssu_two_wire && !i_ssu_three_wire && i_cmp_a_inv_en
      && i_dir[PIN_SDA]
      |=> o_pin_oe[PIN_SDA] && o_pin_out[PIN_SDA] == $past(i_cmp_a_inv_wave))
      else $error("compare waveform not on pin 0");

   a_pc0_gate: assert property (
      !i_rst |=> o_pin0_change_en == ($past(i_global_irq_en) && $past(i_pin_change_group0_en)
          && !$past(i_ssu_two_wire) && !$past(i_ssu_three_wire)
          && !($past(i_cmp_a_inv_en) && !$past(i_prog_mode))))
      else $error("pin 0 change enable wrong");

   a_pin0_wake: assert property (
      i_sleep && i_global_irq_en && i_pin_change_group0_en && !i_ssu_two_wire
      && !i_ssu_three_wire && !i_cmp_a_inv_en |=> o_input_en[PIN_SDA])
      else $error("pin 0 input off in sleep");

   a_reset_pin: assert property (
      i_reset_pin_select
      |=> o_pullup_en[PIN_RST] && !o_pin_oe[PIN_RST] && !o_input_en[PIN_RST])
      else $error("reset pin overrides wrong");

   a_external_irq0_input: assert property (
      i_global_irq_en && i_external_irq0_bit |=> o_input_en[PIN_EXTERNAL_IRQ0]
          && o_pin_oe[PIN_EXTERNAL_IRQ0] == $past(i_dir[PIN_EXTERNAL_IRQ0]))
      else $error("pin 6 input not forced on");

   a_external_irq0_gate: assert property (
      $rose(o_external_irq0_en) |-> $past(i_global_irq_en) && $past(i_external_irq0_bit))
      else $error("irq0 enabled without both bits");

   a_xtal_pins: assert property (
      !i_xtal_out_pin_as_io
      |=> !o_pullup_en[PIN_XOUT] && !o_pin_oe[PIN_XOUT] && o_input_en[PIN_XOUT] == 1'b0)
      else $error("crystal pin overrides wrong");

   a_ext_clock: assert property (
      i_external_clock_sel |=> o_input_en[PIN_XIN] && !o_grp1_change_en[0])
      else $error("external clock input not enabled");

   a_grp1_gate: assert property (
      !(i_global_irq_en && i_pin_change_group1_en) |=> o_grp1_change_en == 4'h0)
      else $error("group 1 enable without gating");

   a_no_value_ovr: assert property (
      !i_rst |=> o_pin_out[PIN_RST:PIN_XIN] == $past(i_port_out[PIN_RST:PIN_XIN]))
      else $error("pins 7 to 4 value overridden");

   a_plain_pins: assert property (
      !i_rst |=> o_pin_oe[3:1] == $past(i_dir[3:1])
          && o_pullup_en[3:1] == ($past(i_port_out[3:1]) & ~$past(i_dir[3:1])))
      else $error("plain pin attributes wrong");

   c_two_wire_low: cover property (i_ssu_two_wire && i_dir[PIN_SDA] && !i_shift_out
                                   ##1 o_pin_oe[PIN_SDA]);
   c_pwm_out: cover property (cmp_a_on && i_dir[PIN_SDA] ##1 o_pin_out[PIN_SDA]);
   c_reset_pin: cover property (i_reset_pin_select ##1 o_pullup_en[PIN_RST]);
   c_grp1_live: cover property (o_grp1_change_en == 4'hf);

endmodule

// *** src/pbao_pkg.sv ***
// Shared constants for the port-B alternate function override block.
package pbao_pkg;

   // Port width and pin positions.
   localparam int unsigned PORT_W   = 8;
   localparam int unsigned PIN_SDA  = 0;
   localparam int unsigned PIN_XIN  = 4;
   localparam int unsigned PIN_XOUT = 5;
   localparam int unsigned PIN_EXTERNAL_IRQ0 = 6;
   localparam int unsigned PIN_RST  = 7;
   localparam int unsigned GRP1_W   = 4;

   // Fixed override enables and values.
   localparam logic OVR_ON         = 1'b1;
   localparam logic OVR_OFF        = 1'b0;
   localparam logic RST_PULL_VAL   = 1'b1;
   localparam logic RST_DIR_VAL    = 1'b0;
   localparam logic XTAL_PULL_VAL  = 1'b0;
   localparam logic XTAL_DIR_VAL   = 1'b0;
   localparam logic INPUT_ON_VAL   = 1'b1;
   localparam logic SDA_VALUE_VAL  = 1'b0;

   // Layout of the registered output word.
   localparam int unsigned OFS_VAL   = 0;
   localparam int unsigned OFS_OE    = 8;
   localparam int unsigned OFS_PULL  = 16;
   localparam int unsigned OFS_INEN  = 24;
   localparam int unsigned OFS_SHIN  = 32;
   localparam int unsigned OFS_EXTERNAL_IRQ0  = 33;
   localparam int unsigned OFS_PC0   = 34;
   localparam int unsigned OFS_GRP1  = 35;
   localparam int unsigned OUT_W     = 39;

   // Every output is inactive after reset: drivers off, pulls off, inputs off.
   localparam logic [OUT_W-1:0] OUT_RESET = 39'h00_0000_0000;

endpackage

// *** src/pbao_ovr_mux.sv ***
`timescale 1ns/100ps
// Per-pin selection between override values and the normal port function.
module pbao_ovr_mux
#(
   parameter int unsigned W = 8
)
(
   // Normal port function.
   input  wire logic [W-1:0] i_port_out,
   input  wire logic [W-1:0] i_dir,
   input  wire logic         i_sleep,
   // Override enables and values.
   input  wire logic [W-1:0] i_pullup_override_en,
   input  wire logic [W-1:0] i_pullup_override_val,
   input  wire logic [W-1:0] i_direction_override_en,
   input  wire logic [W-1:0] i_direction_override_val,
   input  wire logic [W-1:0] i_port_value_override_en,
   input  wire logic [W-1:0] i_port_value_override_val,
   input  wire logic [W-1:0] i_input_enable_override_en,
   input  wire logic [W-1:0] i_input_enable_override_val,
   // Resolved pin attributes.
   output logic      [W-1:0] o_pull,
   output logic      [W-1:0] o_dir,
   output logic      [W-1:0] o_val,
   output logic      [W-1:0] o_inen
);

   // Bitwise pick of the override value where its enable is set.
   function automatic logic [W-1:0] pick(input logic [W-1:0] en,
                                         input logic [W-1:0] ov,
                                         input logic [W-1:0] nv);
      pick = (en & ov) | (~en & nv);
   endfunction

   // The pull-up is normally on only for an input whose port bit is set.
   // Input buffers are normally switched off in sleep to save power.
   always_comb
   begin
      o_pull = pick(i_pullup_override_en, i_pullup_override_val, i_port_out & ~i_dir);
      o_dir  = pick(i_direction_override_en, i_direction_override_val, i_dir);
      o_val  = pick(i_port_value_override_en, i_port_value_override_val, i_port_out);
      o_inen = pick(i_input_enable_override_en, i_input_enable_override_val, {W{~i_sleep}});
   end

endmodule

// *** src/pbao_out_reg.sv ***
`timescale 1ns/100ps
// Output register bank so every pin control leaves the block from a flop.
module pbao_out_reg
#(
   parameter int unsigned     W   = 8,
   parameter logic [W-1:0]    RST = '0
)
(
   // Clock and reset.
   input  wire logic         i_sys_clk,
   input  wire logic         i_rst,
   // Data.
   input  wire logic [W-1:0] i_d,
   output logic      [W-1:0] o_q
);

   // One cycle of latency is traded for glitch-free pad controls.
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
         o_q <= RST;
      else
         o_q <= i_d;
   end

endmodule

// *** dv/pbao_board.sv ***
`timescale 1ns/100ps
// Board-side model of the port-B pads: resolves each pin from the pad driver,
// an external source and the internal pull-up.
module pbao_board
   import pbao_pkg::*;
(
   // Clock.
   input  wire logic              i_sys_clk,
   // Pad controls from the block.
   input  wire logic [PORT_W-1:0] i_pin_out,
   input  wire logic [PORT_W-1:0] i_pin_oe,
   input  wire logic [PORT_W-1:0] i_pullup_en,
   // External drivers on the board.
   input  wire logic [PORT_W-1:0] i_ext_en,
   input  wire logic [PORT_W-1:0] i_ext_val,
   // Resolved pin levels.
   output logic      [PORT_W-1:0] o_level
);
   logic [PORT_W-1:0] float_val = '0; // Known start, else a floating pin stays unknown.

   // A floating pin wanders every cycle, so a stale value is never mistaken for data.
   always_ff @(posedge i_sys_clk)
   begin
      float_val <= ~o_level;
   end

   // The pad driver wins, then an external driver, then the pull-up.
   always_comb
   begin
      for (int b = 0; b < PORT_W; b++)
      begin
         if (i_pin_oe[b])
            o_level[b] = i_pin_out[b]; // Driver only while enabled.
         else if (i_ext_en[b])
            o_level[b] = i_ext_val[b];
         else if (i_pullup_en[b])
            o_level[b] = 1'b1;
         else
            o_level[b] = float_val[b];
      end
   end
endmodule

// *** dv/tb_pbao_top.sv ***
`timescale 1ns/100ps
// Self-checking bench for the port-B override block.
module tb_pbao_top;
   import pbao_pkg::*;
   logic       clk = 1'b0, rst = 1'b1, sleep = 1'b0, two = 1'b0, three = 1'b0;
   logic       shift = 1'b0, start_ie = 1'b0, prog = 1'b0, cmp_en = 1'b0, wave = 1'b0;
   logic       t0clk = 1'b0, gie = 1'b0, pc0 = 1'b0, pc1 = 1'b0, external_irq0 = 1'b0;
   logic       rsel = 1'b0, io4 = 1'b1, io5 = 1'b1, extclk = 1'b0;
   logic [7:0] port = 8'h00, dir = 8'h00, ext_en = 8'h00, ext_val = 8'h00;
   logic [7:0] level, p_out, p_oe, p_pull, p_inen;
   logic       shin, irq0_en, pc0_en;
   logic [3:0] grp1;
   int         failures = 0, checks_done = 0;

   pbao_top u_pbao_top (.i_sys_clk(clk), .i_rst(rst), .i_port_out(port), .i_dir(dir),
      .i_pin_in(level), .i_sleep(sleep), .i_ssu_two_wire(two), .i_ssu_three_wire(three),
      .i_shift_out(shift), .i_ssu_start_irq_en(start_ie), .i_prog_mode(prog),
      .i_cmp_a_inv_en(cmp_en), .i_cmp_a_inv_wave(wave), .i_timer0_external_clock_sel(t0clk),
      .i_global_irq_en(gie), .i_pin_change_group0_en(pc0), .i_pin_change_group1_en(pc1),
      .i_external_irq0_bit(external_irq0), .i_reset_pin_select(rsel), .i_xtal_in_pin_as_io(io4),
      .i_xtal_out_pin_as_io(io5), .i_external_clock_sel(extclk), .o_pin_out(p_out),
      .o_pin_oe(p_oe), .o_pullup_en(p_pull), .o_input_en(p_inen), .o_shift_data_in(shin),
      .o_external_irq0_en(irq0_en), .o_pin0_change_en(pc0_en), .o_grp1_change_en(grp1));

   pbao_board u_pbao_board (.i_sys_clk(clk), .i_pin_out(p_out), .i_pin_oe(p_oe),
      .i_pullup_en(p_pull), .i_ext_en(ext_en), .i_ext_val(ext_val), .o_level(level));

   // The 40 MHz system clock.
   initial
   begin
      forever #12.5 clk = ~clk;
   end

   // Compare one value and report a mismatch at once.
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Print the verdict and stop.
   task automatic test_done();
      if (failures == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Outputs answer on the edge that takes the inputs; look just past that edge.
   task automatic settle();
      @(posedge clk);
      #1;
   endtask

   // Return every input to plain port use, awake, with all alternates off.
   task automatic base();
      @(posedge clk);
      {sleep, two, three, shift, start_ie, prog, cmp_en, wave} <= 8'h00;
      {t0clk, gie, pc0, pc1, external_irq0, rsel, extclk} <= 7'h00;
      {io4, io5} <= 2'b11;
      {port, dir, ext_en, ext_val} <= 32'h0000_0000;
   endtask

   // A second reset in mid-run clears the drivers and input enables; release lets them follow again.
   task automatic t_reset();
      base();
      @(posedge clk);
      port <= 8'hff;
      dir <= 8'hff;
      rst <= 1'b1;
      settle();
      check("oe in reset", p_oe, 8'h00);
      check("inen in reset", p_inen, 8'h00);
      @(posedge clk);
      rst <= 1'b0;
      settle();
      check("oe after reset", p_oe, 8'hff);
   endtask

   // With no override every pin follows its port bits.
   task automatic t_normal();
      base();
      @(posedge clk);
      port <= 8'ha5;
      dir <= 8'h3c;
      settle();
      check("normal out", p_out, 8'ha5);
      check("normal oe", p_oe, 8'h3c);
      check("normal pull", p_pull, 8'h81);
      check("normal inen", p_inen, 8'hff);
   endtask

   // Two-wire data pin: open collector, pull-up forced off.
   task automatic t_two_wire();
      logic [2:0] c;
      base();
      for (int k = 0; k < 8; k++)
      begin
         c = 3'(k);
         @(posedge clk);
         two <= 1'b1;
         {dir[0], port[0], shift} <= c;
         settle();
         check("sda oe", {7'h00, p_oe[0]}, {7'h00, c[2] & ~(c[1] & c[0])});
         check("sda pull", {7'h00, p_pull[0]}, 8'h00);
         if (c[2])
            check("sda out", {7'h00, p_out[0]}, 8'h00);
      end
   endtask

   // Three-wire mode reads the data pin without touching port control.
   task automatic t_three_wire();
      base();
      for (int k = 0; k < 2; k++)
      begin
         @(posedge clk);
         three <= 1'b1;
         port[0] <= 1'b1;
         ext_en[0] <= 1'b1;
         ext_val[0] <= 1'(k);
         settle();
         check("di oe", {7'h00, p_oe[0]}, 8'h00);
         check("di pull", {7'h00, p_pull[0]}, 8'h01);
         check("di level", {7'h00, shin}, {7'h00, 1'(k)});
      end
   endtask

   // Inverted compare waveform owns pin 0 unless programming uses it.
   task automatic t_compare();
      base();
      for (int k = 0; k < 3; k++)
      begin
         @(posedge clk);
         {cmp_en, dir[0]} <= 2'b11;
         {prog, wave, port[0]} <= (k == 0) ? 3'b010 : (k == 1) ? 3'b001 : 3'b101;
         settle();
         check("cmp out", {7'h00, p_out[0]}, {7'h00, k != 1});
      end
   endtask

   // Pin 0 change interrupt and its input buffer during sleep, then the start interrupt.
   task automatic t_pin0_change();
      base();
      for (int k = 0; k < 4; k++)
      begin
         @(posedge clk);
         {sleep, pc0} <= 2'b11;
         gie <= (k != 1);
         two <= (k >= 2);
         start_ie <= (k == 3);
         settle();
         check("pc0 en", {7'h00, pc0_en}, {7'h00, k == 0});
         check("pc0 inen", {7'h00, p_inen[0]}, {7'h00, k == 0 || k == 3});
      end
   endtask

   // Reset pin and external interrupt pin overrides.
   task automatic t_pins_7_6();
      base();
      @(posedge clk);
      {rsel, gie, pc1, external_irq0} <= 4'hf;
      port <= 8'h40;
      dir <= 8'hc0;
      settle();
      check("p7 pull", {7'h00, p_pull[7]}, 8'h01);
      check("p7 oe", {7'h00, p_oe[7]}, 8'h00);
      check("p7 6 inen", {6'h00, p_inen[7:6]}, 8'h01);
      check("p7 6 out", {6'h00, p_out[7:6]}, 8'h01);
      check("irq0 en", {7'h00, irq0_en}, 8'h01);
      check("grp1 masked", {4'h0, grp1}, 8'h03);
      @(posedge clk);
      {rsel, external_irq0, t0clk, sleep} <= 4'h3;
      settle();
      check("p7 6 sleep inen", {6'h00, p_inen[7:6]}, 8'h02);
      check("grp1 timer", {4'h0, grp1}, 8'h0b);
      @(posedge clk);
      {gie, external_irq0} <= 2'b01;
      settle();
      check("irq0 no gie", {7'h00, irq0_en}, 8'h00);
      check("grp1 no gie", {4'h0, grp1}, 8'h00);
   endtask

   // Crystal pins taken by the clock fuses, then an external clock on pin 4.
   task automatic t_xtal();
      base();
      @(posedge clk);
      {io4, io5, gie, pc1} <= 4'h3;
      port <= 8'h30;
      dir <= 8'h30;
      settle();
      check("xtal pull", {6'h00, p_pull[5:4]}, 8'h00);
      check("xtal oe", {6'h00, p_oe[5:4]}, 8'h00);
      check("xtal out", {6'h00, p_out[5:4]}, 8'h03);
      check("xtal inen", {6'h00, p_inen[5:4]}, 8'h00);
      check("xtal grp1", {6'h00, grp1[1:0]}, 8'h00);
      @(posedge clk);
      {io4, io5, extclk, sleep} <= 4'hf;
      settle();
      check("ext clk inen", {6'h00, p_inen[5:4]}, 8'h03);
      check("ext clk grp1", {6'h00, grp1[1:0]}, 8'h02);
      @(posedge clk);
      {gie, pc1} <= 2'b00;
      settle();
      check("ext clk only", {6'h00, p_inen[5:4]}, 8'h01);
   endtask

   // Main sequence: reset for 12 cycles, then every scenario in turn.
   initial
   begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_normal();
      t_two_wire();
      t_three_wire();
      t_compare();
      t_pin0_change();
      t_pins_7_6();
      t_xtal();
      test_done();
   end

   // The scenarios need under a hundred cycles; cut a hang well beyond that.
   initial
   begin
      repeat (2000) @(posedge clk);
      failures++;
      test_done();
   end
endmodule
